// ===== hdl/cmel_loader.sv
// Operation
// R01: Strap mode takes the whole configuration from strap pin levels only.
// R02: Primary mode drives the management bus and reads configuration from EEPROM.
// R03: Load-complete output goes low after an error-free EEPROM read.
// R04: Load-complete asserts about 7.5 ms after load request.
// R05: Secondary access stays enabled before, during and after the EEPROM read.
// R06: External primary accessing during the load must arbitrate.
// R07: In secondary mode an external primary writes the configuration.
// R08: External primary waits 50 ms after power settles before access.
// R09: Repeated-START setup 2 us, START hold 1.5 us before first clock.
// R10: On lost arbitration release the bus and retry once it is free.
`timescale 1ns/1ps
`default_nettype none
module cmel_fifo #(parameter int W = 8, parameter int D = 32) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } cmel_fst_t;
    cmel_fst_t r, n;
    logic [W-1:0] mem [D];
    logic [AW:0] used;
    assign used = r.wp - r.rp;
    assign in_ready = used != (AW+1)'(D);
    assign out_valid = used != '0;
    assign out_data = mem[r.rp[AW-1:0]];
    always_comb begin
        n = r;
        if (in_valid && in_ready) begin
            n.wp = r.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            n.rp = r.rp + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[r.wp[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : cmel_fifo

module cmel_link import cmel_pkg::*; #(parameter int CFG_BYTES = 16, parameter logic [6:0] EE_ADDR = 7'h50) (
    input wire logic clk_link,
    input wire logic rst_b,
    input wire logic go_t,
    input wire logic ack_t,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe,
    output logic sda_oe,
    output logic req_t,
    output logic done_t,
    output logic err_t,
    output logic [7:0] data
);
    localparam int IW = $clog2(CFG_BYTES);
    typedef enum logic [2:0] {ls_idle, ls_buswait, ls_start, ls_low, ls_high, ls_wait, ls_rsu, ls_stop} cmel_lst_t;
    typedef struct packed {
        cmel_lst_t st;
        logic [CNT_W-1:0] cnt;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [IW-1:0] idx;
        logic fail;
        logic scl_oe, sda_oe, req_t, done_t, err_t;
        logic [7:0] data;
        logic scl1, scl2, sda1, sda2, go1, go2, go3, ack1, ack2, ack3;
    } cmel_lnk_t;
    cmel_lnk_t r, n;
    logic lrst1, lrst_b, last, drive_bit, arb_lost;
    function automatic logic [7:0] tx_byte(input logic [1:0] ph, input logic [IW-1:0] idx);
        if (ph == PH_ADDR_W) return {EE_ADDR, 1'b0};
        else if (ph == PH_WORD) return WORD_ADDR + 8'(idx);
        else if (ph == PH_ADDR_R) return {EE_ADDR, 1'b1};
        else return BYTE_IDLE;
    endfunction : tx_byte
    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            lrst1 <= 1'b0;
            lrst_b <= 1'b0;
        end else begin
            lrst1 <= 1'b1;
            lrst_b <= lrst1;
        end
    end
    assign last = r.idx == IW'(CFG_BYTES - 1);
    assign drive_bit = (r.bitn < ACK_BIT) ? ((r.ph == PH_DATA) ? 1'b1 : r.sh[7]) : ((r.ph == PH_DATA) ? last : 1'b1);
    // R10 lost arbitration
    assign arb_lost = (r.st == ls_high) && (r.cnt == HIGH_C - CNT_ONE) && (r.bitn < ACK_BIT) && (r.ph != PH_DATA)
        && r.sh[7] && !r.sda2;
    always_comb begin
        n = r;
        n.scl1 = scl_i;
        n.scl2 = r.scl1;
        n.sda1 = sda_i;
        n.sda2 = r.sda1;
        n.go1 = go_t;
        n.go2 = r.go1;
        n.go3 = r.go2;
        n.ack1 = ack_t;
        n.ack2 = r.ack1;
        n.ack3 = r.ack2;
        n.cnt = r.cnt + CNT_ONE;
        case (r.st)
            ls_idle: begin
                n.cnt = '0;
                // R02 start fetch
                if (r.go2 != r.go3) begin
                    n.st = ls_buswait;
                    n.ph = PH_ADDR_W;
                    n.idx = '0;
                    n.fail = 1'b0;
                end
            end
            ls_buswait: begin
                // R10 wait bus free
                if (!(r.scl2 && r.sda2)) begin
                    n.cnt = '0;
                end else if (r.cnt == BUF_C) begin
                    n.st = ls_start;
                    n.cnt = '0;
                    n.sda_oe = 1'b1;
                end
            end
            ls_start: begin
                // R09 start hold
                if (r.cnt == HD_STA_C - CNT_ONE) begin
                    n.st = ls_low;
                    n.cnt = '0;
                    n.scl_oe = 1'b1;
                    n.bitn = '0;
                    n.sh = tx_byte(r.ph, r.idx);
                end
            end
            ls_low: begin
                if (r.cnt == HD_DAT_C) begin
                    n.sda_oe = !drive_bit;
                end
                if (r.cnt == LOW_C - CNT_ONE) begin
                    n.st = ls_high;
                    n.cnt = '0;
                    n.scl_oe = 1'b0;
                end
            end
            ls_high: begin
                if (r.cnt == HIGH_C - CNT_ONE) begin
                    n.cnt = '0;
                    n.scl_oe = 1'b1;
                    n.st = ls_low;
                    // R10 release and retry
                    if (arb_lost) begin
                        n.scl_oe = 1'b0;
                        n.sda_oe = 1'b0;
                        n.st = ls_buswait;
                        n.ph = PH_ADDR_W;
                    end else if (r.bitn < ACK_BIT) begin
                        n.bitn = r.bitn + BIT_ONE;
                        n.sh = {r.sh[6:0], r.sda2};
                    end else begin
                        n.bitn = '0;
                        if (r.ph != PH_DATA && r.sda2) begin
                            n.fail = 1'b1;
                            n.err_t = ~r.err_t;
                            n.st = ls_stop;
                        end else if (r.ph == PH_ADDR_W) begin
                            n.ph = PH_WORD;
                            n.sh = tx_byte(PH_WORD, r.idx);
                        end else if (r.ph == PH_WORD) begin
                            n.ph = PH_ADDR_R;
                            n.st = ls_rsu;
                        end else if (r.ph == PH_ADDR_R) begin
                            n.ph = PH_DATA;
                        end else begin
                            n.data = r.sh;
                            n.req_t = ~r.req_t;
                            n.st = ls_wait;
                        end
                    end
                end
            end
            ls_wait: begin
                n.cnt = '0;
                if (r.ack2 != r.ack3) begin
                    n.st = last ? ls_stop : ls_low;
                    n.idx = last ? r.idx : r.idx + 1'b1;
                end
            end
            ls_rsu: begin
                // R09 repeated start setup
                n.scl_oe = r.cnt < LOW_C - CNT_ONE;
                if (r.cnt == HD_DAT_C) begin
                    n.sda_oe = 1'b0;
                end
                if (r.cnt == LOW_C + SU_STA_C - CNT_ONE) begin
                    n.st = ls_start;
                    n.cnt = '0;
                    n.sda_oe = 1'b1;
                end
            end
            default: begin
                n.scl_oe = r.cnt < LOW_C - CNT_ONE;
                if (r.cnt == HD_DAT_C) begin
                    n.sda_oe = 1'b1;
                end
                if (r.cnt == LOW_C + SU_STO_C - CNT_ONE) begin
                    n.st = ls_idle;
                    n.sda_oe = 1'b0;
                    n.done_t = r.fail ? r.done_t : ~r.done_t;
                end
            end
        endcase
    end
    always_ff @(posedge clk_link or negedge lrst_b) begin
        if (!lrst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign scl_oe = r.scl_oe;
    assign sda_oe = r.sda_oe;
    assign req_t = r.req_t;
    assign done_t = r.done_t;
    assign err_t = r.err_t;
    assign data = r.data;
    a_start_hold: assert property (@(posedge clk_link) disable iff (!lrst_b) // R09
        (r.st == ls_start) && (r.cnt == HD_STA_C - CNT_ONE) |=> (r.st == ls_low) && scl_oe && sda_oe)
        else $error("start hold wrong");
    a_rstart_setup: assert property (@(posedge clk_link) disable iff (!lrst_b) // R09
        (r.st == ls_rsu) && (r.cnt == LOW_C + SU_STA_C - CNT_ONE) |=> (r.st == ls_start) && sda_oe && !scl_oe)
        else $error("repeated start setup wrong");
    a_arb_release: assert property (@(posedge clk_link) disable iff (!lrst_b) // R10
        arb_lost |=> !scl_oe && !sda_oe && (r.st == ls_buswait) && (r.ph == PH_ADDR_W))
        else $error("bus not released after arbitration loss");
    c_arb_lost: cover property (@(posedge clk_link) disable iff (!lrst_b) arb_lost);
endmodule : cmel_link

module cmel_loader import cmel_pkg::*; #(
    parameter int CFG_BYTES = 16,
    parameter int FIFO_D = 32,
    parameter int LOAD_CYC = EEPROM_CYC,
    parameter logic [6:0] EE_ADDR = 7'h50
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CLK_LINK,
    input wire logic [1:0] MODE,
    input wire logic [7:0] STRAP_CFG,
    input wire logic READ_EN_N,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    output logic ALL_DONE_N,
    output logic LOAD_ERR,
    output logic SEC_ENABLE,
    output logic CFG_VALID,
    output logic [7:0] CFG_DATA,
    input wire logic CFG_READY
);
    localparam int TW = $clog2(LOAD_CYC + 1);
    typedef struct packed {
        logic [1:0] mode1, mode2, mode;
        logic warm1, warm2, mode_ok;
        logic [7:0] strap1, strap2;
        logic rd1, rd2, rd3, req1, req2, req3, dn1, dn2, dn3, er1, er2, er3;
        logic go_t, ack_t, trun, ldone, done_n, err, busy, spush, sec_en, ov;
        logic [TW-1:0] tmr;
        logic [7:0] od;
    } cmel_sys_t;
    cmel_sys_t r, n;
    logic go_t, ack_t, req_t, done_t, err_t, fin_valid, fin_ready, fout_valid, fout_ready, pend;
    logic [7:0] link_data, fin_data, fout_data;
    assign pend = (r.mode == MODE_PRIMARY) && (r.req2 != r.req3);
    assign fin_valid = r.mode_ok && (pend || (r.mode == MODE_STRAP && !r.spush));
    // R01 strap word only
    assign fin_data = (r.mode == MODE_STRAP) ? r.strap2 : link_data;
    assign fout_ready = !r.ov || CFG_READY;
    assign go_t = r.go_t;
    assign ack_t = r.ack_t;
    always_comb begin
        n = r;
        n.mode1 = MODE;
        n.mode2 = r.mode1;
        n.strap1 = STRAP_CFG;
        n.strap2 = r.strap1;
        n.rd1 = READ_EN_N;
        n.rd2 = r.rd1;
        n.rd3 = r.rd2;
        n.req1 = req_t;
        n.req2 = r.req1;
        n.dn1 = done_t;
        n.dn2 = r.dn1;
        n.dn3 = r.dn2;
        n.er1 = err_t;
        n.er2 = r.er1;
        n.er3 = r.er2;
        n.warm1 = 1'b1;
        n.warm2 = r.warm1;
        if (r.warm2 && !r.mode_ok) begin
            n.mode = r.mode2;
            n.mode_ok = 1'b1;
        end
        // R05 secondary kept alive
        n.sec_en = r.mode_ok && (r.mode != MODE_STRAP);
        if (fin_valid && fin_ready) begin
            n.spush = r.spush || (r.mode == MODE_STRAP);
            n.req3 = r.req2;
            n.ack_t = pend ? ~r.ack_t : r.ack_t;
        end
        // R02 request starts fetch
        if (r.mode_ok && r.mode == MODE_PRIMARY && r.rd3 && !r.rd2 && !r.busy) begin
            n.go_t = ~r.go_t;
            n.busy = 1'b1;
            n.tmr = '0;
            n.trun = 1'b1;
            n.ldone = 1'b0;
            n.err = 1'b0;
            n.done_n = 1'b1;
        end
        if (r.trun && r.tmr != TW'(LOAD_CYC)) begin
            n.tmr = r.tmr + 1'b1;
        end
        if (r.dn2 != r.dn3) begin
            n.ldone = 1'b1;
            n.busy = 1'b0;
        end
        if (r.er2 != r.er3) begin
            n.err = 1'b1;
            n.busy = 1'b0;
        end
        // R03 R04 done after load and time
        if (r.ldone && !r.err && r.tmr == TW'(LOAD_CYC)) begin
            n.done_n = 1'b0;
        end
        if (fout_ready) begin
            n.ov = fout_valid;
            n.od = fout_data;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            r <= '0;
            r.done_n <= 1'b1;
            r.rd1 <= 1'b1;
            r.rd2 <= 1'b1;
            r.rd3 <= 1'b1;
        end else begin
            r <= n;
        end
    end
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign ALL_DONE_N = r.done_n;
    assign LOAD_ERR = r.err;
    assign SEC_ENABLE = r.sec_en;
    assign CFG_VALID = r.ov;
    assign CFG_DATA = r.od;
    cmel_fifo #(.W(8), .D(FIFO_D)) u_fifo (.clk(CLK_SYS), .rst_b(RST_B), .in_valid(fin_valid),
        .in_ready(fin_ready), .in_data(fin_data), .out_valid(fout_valid), .out_ready(fout_ready),
        .out_data(fout_data));
    cmel_link #(.CFG_BYTES(CFG_BYTES), .EE_ADDR(EE_ADDR)) u_link (.clk_link(CLK_LINK), .rst_b(RST_B),
        .go_t(go_t), .ack_t(ack_t), .scl_i(SCL_I), .sda_i(SDA_I), .scl_oe(SCL_OE), .sda_oe(SDA_OE),
        .req_t(req_t), .done_t(done_t), .err_t(err_t), .data(link_data));
    a_strap_data: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R01
        fin_valid && fin_ready && (r.mode == MODE_STRAP) |-> fin_data == r.strap2 && !r.sec_en)
        else $error("strap mode pushed non-strap data");
    a_go_primary: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R02
        (r.go_t != $past(r.go_t)) |-> r.mode == MODE_PRIMARY && r.busy)
        else $error("fetch started outside primary mode");
    a_done_clean: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R03
        $fell(ALL_DONE_N) |-> r.ldone && !r.err)
        else $error("done asserted without clean load");
    a_done_time: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R04
        !ALL_DONE_N |-> r.tmr == TW'(LOAD_CYC))
        else $error("done asserted before load time");
    a_sec_alive: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R05
        r.mode_ok && (r.mode == MODE_PRIMARY) ##1 r.mode_ok |-> SEC_ENABLE)
        else $error("secondary access disabled in primary mode");
    c_done: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $fell(ALL_DONE_N));
    c_strap: cover property (@(posedge CLK_SYS) disable iff (!RST_B) fin_valid && fin_ready && r.mode == MODE_STRAP);
    c_stall: cover property (@(posedge CLK_SYS) disable iff (!RST_B) fin_valid && !fin_ready);
endmodule : cmel_loader
`default_nettype wire

// ===== pkg/cmel_pkg.sv
package cmel_pkg;
    localparam real SYS_CLK_NS = 20.0;
    localparam real LINK_CLK_NS = 30.0;
    localparam logic [1:0] MODE_STRAP = 2'h0;
    localparam logic [1:0] MODE_PRIMARY = 2'h1;
    localparam logic [1:0] MODE_SECONDARY = 2'h2;
    localparam real T_EEPROM_MS = 7.5;
    localparam int EEPROM_CYC = int'($ceil(T_EEPROM_MS * 1.0e6 / SYS_CLK_NS));
    localparam real T_LOW_M_US = 1.90;
    localparam real T_HIGH_M_US = 1.40;
    localparam real T_SU_STA_M_US = 2.0;
    localparam real T_HD_STA_M_US = 1.5;
    localparam real T_HD_DAT_M_US = 0.5;
    localparam real T_SU_STO_M_US = 1.5;
    localparam real T_BUF_US = 1.3;
    localparam int CNT_W = 8;
    function automatic int us2cyc(input real us);
        return int'($ceil(us * 1000.0 / LINK_CLK_NS));
    endfunction : us2cyc
    localparam logic [CNT_W-1:0] LOW_C = CNT_W'(us2cyc(T_LOW_M_US));
    localparam logic [CNT_W-1:0] HIGH_C = CNT_W'(us2cyc(T_HIGH_M_US));
    localparam logic [CNT_W-1:0] SU_STA_C = CNT_W'(us2cyc(T_SU_STA_M_US));
    localparam logic [CNT_W-1:0] HD_STA_C = CNT_W'(us2cyc(T_HD_STA_M_US));
    localparam logic [CNT_W-1:0] HD_DAT_C = CNT_W'(us2cyc(T_HD_DAT_M_US));
    localparam logic [CNT_W-1:0] SU_STO_C = CNT_W'(us2cyc(T_SU_STO_M_US));
    localparam logic [CNT_W-1:0] BUF_C = CNT_W'(us2cyc(T_BUF_US));
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [7:0] WORD_ADDR = 8'h00;
    localparam logic [7:0] BYTE_IDLE = 8'hFF;
    localparam logic [1:0] PH_ADDR_W = 2'h0;
    localparam logic [1:0] PH_WORD = 2'h1;
    localparam logic [1:0] PH_ADDR_R = 2'h2;
    localparam logic [1:0] PH_DATA = 2'h3;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] BIT_ONE = 4'h1;
endpackage : cmel_pkg

// ===== tb/cmel_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmel_eeprom_model #(parameter logic [6:0] DEV_ADDR = 7'h50) (
    input wire logic scl,
    input wire logic sda,
    input wire logic refuse,
    output logic sda_oe
);
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic [7:0] dat = 8'h00;
    int ph = 3;
    int b = 0;
    initial sda_oe = 1'b0;
    // Start or repeated start
    always @(negedge sda) if (scl === 1'b1) begin
        ph = 0;
        b = 0;
        sda_oe = 1'b0;
    end
    // Stop frees the line
    always @(posedge sda) if (scl === 1'b1) begin
        ph = 3;
        sda_oe = 1'b0;
    end
    // Shift in bits, master nack ends a read
    always @(posedge scl) if (ph != 3) begin
        if (b < 8)
            sh = {sh[6:0], sda};
        if (ph == 2 && b == 8 && sda === 1'b1)
            ph = 3;
        b = b + 1;
    end
    // Acknowledge and data drive
    always @(negedge scl) if (ph != 3) begin
        sda_oe = 1'b0;
        if (b == 8 && ph == 0) begin
            ph = (sh[7:1] == DEV_ADDR && !refuse) ? (sh[0] ? 2 : 1) : 3;
            sda_oe = (ph != 3);
        end else if (b == 8 && ph == 1) begin
            ptr = sh;
            sda_oe = 1'b1;
        end
        if (b == 9) begin
            b = 0;
            if (ph == 2) begin
                dat = 8'h30 + ptr;
                ptr = ptr + 8'h01;
            end
        end
        if (ph == 2 && b < 8)
            sda_oe = ~dat[7 - b];
    end
endmodule : cmel_eeprom_model
`default_nettype wire

// ===== tb/cmel_loader_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cmel_loader_bench import cmel_pkg::*; ;
    localparam int LCYC = 18000;
    localparam int NB = 4;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] mode = MODE_STRAP;
    logic [7:0] strap = 8'h00;
    logic read_en_n = 1'b1;
    logic cfg_ready = 1'b0;
    logic ext_sda_oe = 1'b0;
    logic refuse = 1'b0;
    logic scl_o, scl_oe, sda_o, sda_oe, mem_sda_oe;
    logic all_done_n, load_err, sec_enable, cfg_valid;
    logic [7:0] cfg_data;
    logic [CNT_W-1:0] su_seen = 8'h00;
    logic [CNT_W-1:0] hd_seen = 8'h00;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_bus = 0;
    int n_sta = 0;
    real t_rise = 0.0;
    real t_sta = 0.0;
    wire scl_w = scl_oe ? scl_o : 1'b1;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~mem_sda_oe & ~ext_sda_oe;
    always #10 clk_sys = ~clk_sys;
    always #15 clk_link = ~clk_link;
    cmel_loader #(.CFG_BYTES(NB), .LOAD_CYC(LCYC)) uut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .CLK_LINK(clk_link), .MODE(mode),
        .STRAP_CFG(strap), .READ_EN_N(read_en_n), .SCL_I(scl_w), .SCL_O(scl_o),
        .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ALL_DONE_N(all_done_n), .LOAD_ERR(load_err), .SEC_ENABLE(sec_enable),
        .CFG_VALID(cfg_valid), .CFG_DATA(cfg_data), .CFG_READY(cfg_ready)
    );
    cmel_eeprom_model #(.DEV_ADDR(7'h50)) mem (.scl(scl_w), .sda(sda_w), .refuse(refuse), .sda_oe(mem_sda_oe));
    // Bus monitors
    always @(posedge scl_w) t_rise = $realtime;
    always @(posedge scl_oe) n_bus++;
    always @(negedge sda_w) if (scl_w === 1'b1) begin
        n_sta++;
        t_sta = $realtime;
        if (n_sta == 2)
            su_seen = CNT_W'($rtoi((t_sta - t_rise) / LINK_CLK_NS + 0.5));
    end
    always @(negedge scl_w) if (t_sta > 0.0) begin
        if (n_sta == 1)
            hd_seen = CNT_W'($rtoi(($realtime - t_sta) / LINK_CLK_NS + 0.5));
        t_sta = 0.0;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic restart(input logic [1:0] m);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        mode <= m;
        read_en_n <= 1'b1;
        cfg_ready <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        n_bus = 0;
        n_sta = 0;
    endtask : restart
    task automatic take(input int n, input logic [7:0] first, input logic [7:0] step);
        int k;
        int w;
        k = 0;
        w = 0;
        while (k < n && w < 40000) begin
            @(posedge clk_sys);
            w++;
            if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
                chk_byte("cfg data", first + step * k[7:0], cfg_data);
                k++;
            end
            cfg_ready <= w[3];
        end
        chk_bit("all words", 1'b1, k == n);
    endtask : take
    task automatic strap_mode();
        strap <= 8'hA5;
        restart(MODE_STRAP);
        take(1, 8'hA5, 8'h00);
        repeat (200) @(posedge clk_sys);
        chk_bit("strap bus idle", 1'b1, n_bus == 0);
        chk_bit("strap responder", 1'b0, sec_enable);
        chk_bit("strap done", 1'b1, all_done_n);
    endtask : strap_mode
    task automatic secondary_mode();
        restart(MODE_SECONDARY);
        read_en_n <= 1'b0;
        repeat (300) @(posedge clk_sys);
        chk_bit("sec responder", 1'b1, sec_enable);
        chk_bit("sec bus idle", 1'b1, n_bus == 0);
        chk_bit("sec no data", 1'b0, cfg_valid);
    endtask : secondary_mode
    task automatic contend();
        @(negedge sda_w iff scl_w === 1'b1);
        @(negedge scl_w);
        #200 ext_sda_oe = 1'b1;
        @(posedge scl_w);
        repeat (80) @(posedge clk_link);
        chk_bit("bus released", 1'b0, scl_oe | sda_oe);
        ext_sda_oe = 1'b0;
    endtask : contend
    task automatic primary_load(input logic lose);
        int t0;
        restart(MODE_PRIMARY);
        chk_bit("responder before", 1'b1, sec_enable);
        read_en_n <= 1'b0;
        t0 = cyc;
        if (lose)
            contend();
        chk_bit("responder during", 1'b1, sec_enable);
        take(NB, 8'h30, 8'h01);
        while (all_done_n !== 1'b0 && cyc - t0 < LCYC + 20)
            @(posedge clk_sys);
        chk_bit("done timing", 1'b1, cyc - t0 >= LCYC && cyc - t0 <= LCYC + 10);
        chk_bit("done level", 1'b0, all_done_n);
        chk_bit("no error", 1'b0, load_err);
        chk_bit("responder after", 1'b1, sec_enable);
        chk_bit("scl drive level", 1'b0, scl_o);
        chk_bit("sda drive level", 1'b0, sda_o);
        if (!lose) begin
            chk_byte("restart setup", SU_STA_C, su_seen);
            chk_byte("start hold", HD_STA_C, hd_seen);
        end
    endtask : primary_load
    task automatic refused_load();
        refuse <= 1'b1;
        restart(MODE_PRIMARY);
        read_en_n <= 1'b0;
        repeat (20000) @(posedge clk_sys) if (load_err === 1'b1) break;
        chk_bit("load error", 1'b1, load_err);
        repeat (LCYC + 50) @(posedge clk_sys);
        chk_bit("no done on error", 1'b1, all_done_n);
        chk_bit("no data on error", 1'b0, cfg_valid);
    endtask : refused_load
    task automatic summarize();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        strap_mode();
        secondary_mode();
        primary_load(1'b0);
        primary_load(1'b1);
        refused_load();
        summarize();
    end
endmodule : cmel_loader_bench
`default_nettype wire
